// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the serial link control register bank.
// Assumes: Zero-wait APB slave; registered outputs follow a register write one edge later.
// Notes:   The bench plays the software side and keeps its ordering duties.
`timescale 1ns/1ps
module tb;

    // ****************************************************************
    // Signals and design instance
    // ****************************************************************
    logic                     clk;
    logic                     resetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [15:0]              paddr;
    logic [31:0]              pwdata;
    logic [3:0]               pstrb;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     sysrefPulse;
    logic                     frameTick;
    logic                     syncSeN;
    logic                     tmstpSyncN;
    logic                     mode64b66b;
    logic [2:0]               modeE;
    logic [4:0]               modeF;
    slcr_pkg::slcr_link_ctl_t linkCtl;
    logic [5:0]               outputModeSelector;
    logic [10:0]              effectiveK;
    logic                     syncRequest;
    logic [10:0]              multiframeCount;
    logic                     multiframeBoundary;
    int                       badCount;
    int                       totalChecks;
    int                       boundaryCount;
    logic [31:0]              rd;
    logic                     er;

    slcr_serial_link_regs #(.KW(11)) slcr_serial_link_regs_inst (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysrefPulse(sysrefPulse), .frameTick(frameTick),
        .syncSeN(syncSeN), .tmstpSyncN(tmstpSyncN), .mode64b66b(mode64b66b),
        .modeE(modeE), .modeF(modeF), .linkCtl(linkCtl),
        .outputModeSelector(outputModeSelector), .effectiveK(effectiveK),
        .syncRequest(syncRequest), .multiframeCount(multiframeCount),
        .multiframeBoundary(multiframeBoundary)
    );

    // ****************************************************************
    // Clock, reset and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #100000;
        badCount++;
        end_sim();
    end

    always @(negedge clk) begin
        if (multiframeBoundary === 1'b1) begin
            boundaryCount++;
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h000000, d}, 4'hf, rd, er);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        apb(a, 1'b0, 32'h00000000, 4'h0, rd, er);
        chk(rd, {24'h000000, exp});
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tick(input logic sref);
        @(posedge clk);
        frameTick   <= ~sref;
        sysrefPulse <= sref;
        @(posedge clk);
        frameTick   <= 1'b0;
        sysrefPulse <= 1'b0;
        settle(1);
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
        pwdata = 32'h0; pstrb = 4'h0; sysrefPulse = 1'b0; frameTick = 1'b0;
        syncSeN = 1'b1; tmstpSyncN = 1'b1; mode64b66b = 1'b0; modeE = 3'h1;
        modeF = 5'h01; badCount = 0; totalChecks = 0; boundaryCount = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        settle(2);
        chk({29'h0, linkCtl}, 32'h1);
        chk({21'h0, effectiveK}, 32'd32);
        chk({31'h0, syncRequest}, 32'h0);
        rdchk(slcr_pkg::ADDR_LINK_ENABLE, 8'h01);
        rdchk(slcr_pkg::ADDR_OUTPUT_MODE, 8'h00);
        rdchk(slcr_pkg::ADDR_FRAMES_M1, 8'h1f);
        rdchk(slcr_pkg::ADDR_SW_SYNC, 8'h01);
        rdchk(slcr_pkg::ADDR_LINK_CONTROL, 8'h03);
        $display("Test reset values done");

        // Masked write is dropped; unmapped places answer with an error.
        apb(slcr_pkg::ADDR_LINK_ENABLE, 1'b1, 32'h0, 4'h0, rd, er);
        rdchk(slcr_pkg::ADDR_LINK_ENABLE, 8'h01);
        apb(16'h0814, 1'b1, 32'h5, 4'hf, rd, er);
        chk({31'h0, er}, 32'h1);
        apb(16'h0000, 1'b0, 32'h0, 4'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        $display("Test bus refusals done");

        wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h00);
        settle(2);
        chk({29'h0, linkCtl}, 32'h6);
        for (int i = 0; i < 3; i++) begin
            tick(i[0]);
        end
        chk({21'h0, multiframeCount}, 32'h0);
        wr(slcr_pkg::ADDR_OUTPUT_MODE, 8'h2a);
        wr(slcr_pkg::ADDR_FRAMES_M1, 8'h03);
        settle(2);
        rdchk(slcr_pkg::ADDR_OUTPUT_MODE, 8'h2a);
        rdchk(slcr_pkg::ADDR_FRAMES_M1, 8'h03);
        chk({26'h0, outputModeSelector}, 32'h2a);
        chk({21'h0, effectiveK}, 32'd4);
        $display("Test disable and config done");

        wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h01);
        settle(2);
        chk({29'h0, linkCtl}, 32'h1);
        tick(1'b0);
        tick(1'b0);
        tick(1'b1);
        chk({21'h0, multiframeCount}, 32'h0);
        boundaryCount = 0;
        for (int i = 1; i <= 3; i++) begin
            tick(1'b0);
            chk({21'h0, multiframeCount}, i);
        end
        tick(1'b0);
        settle(2);
        chk({21'h0, multiframeCount}, 32'h0);
        chk(boundaryCount, 32'h1);
        $display("Test multiframe counter done");

        @(posedge clk);
        mode64b66b <= 1'b1;
        modeE <= 3'h2;
        modeF <= 5'h04;
        settle(3);
        chk({21'h0, effectiveK}, 32'd128);
        @(posedge clk);
        modeE <= 3'h3;
        modeF <= 5'h08;
        settle(3);
        chk({21'h0, effectiveK}, 32'd96);
        @(posedge clk);
        mode64b66b <= 1'b0;
        settle(3);
        chk({21'h0, effectiveK}, 32'd4);
        $display("Test 64b66b length done");

        // Software request under every selector, then pin-driven requests.
        wr(slcr_pkg::ADDR_LINK_ENABLE, 8'h00);
        wr(slcr_pkg::ADDR_SW_SYNC, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(slcr_pkg::ADDR_LINK_CONTROL, {4'h0, s[1:0], 2'h3});
            settle(2);
            chk({31'h0, syncRequest}, 32'h1);
        end
        wr(slcr_pkg::ADDR_SW_SYNC, 8'h01);
        syncSeN <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr(slcr_pkg::ADDR_LINK_CONTROL, {4'h0, s[1:0], 2'h3});
            settle(2);
            chk({31'h0, syncRequest}, {31'h0, s == 0});
        end
        @(posedge clk);
        syncSeN <= 1'b1;
        tmstpSyncN <= 1'b0;
        wr(slcr_pkg::ADDR_LINK_CONTROL, 8'h07);
        settle(2);
        chk({31'h0, syncRequest}, 32'h1);
        wr(slcr_pkg::ADDR_LINK_CONTROL, 8'h0b);
        settle(2);
        chk({31'h0, syncRequest}, 32'h0);
        rdchk(slcr_pkg::ADDR_LINK_CONTROL, 8'h0b);
        $display("Test sync request done");
        end_sim();
    end

endmodule

// ---- logic/slcr_mf_counter.sv ----
// Purpose: Local multiframe counter for the serial link.
// Assumes: frameTick pulses once per frame; kValue is at least one.
// Notes:   Held at zero while disabled, so alignment pulses are ignored then.
`timescale 1ns/1ps
module slcr_mf_counter #(
    parameter int KW = 11
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          enable,
    input  wire logic          sysrefPulse,
    input  wire logic          frameTick,
    input  wire logic [KW-1:0] kValue,
    output logic      [KW-1:0] count,
    output logic               boundary
);

    logic [KW-1:0] count_q;
    logic [KW-1:0] count_d;
    logic          boundary_q;
    logic          atLast;

    assign atLast = (count_q == (kValue - KW'(1)));

    assign count_d = !enable    ? '0 :
                     sysrefPulse ? '0 :
                     !frameTick  ? count_q :
                     atLast      ? '0 : count_q + KW'(1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q    <= '0;
            boundary_q <= 1'b0;
        end else begin
            count_q    <= count_d;
            boundary_q <= enable && !sysrefPulse && frameTick && atLast;
        end
    end

    assign count    = count_q;
    assign boundary = boundary_q;

endmodule

// ---- logic/slcr_pkg.sv ----
// Purpose: Shared constants and types for the serial link control registers.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes:   Register indices are scaled by four to form byte addresses.
package slcr_pkg;

    // ****************************************************************
    // Bus and register map
    // ****************************************************************
    localparam int          APB_AW              = 16;
    localparam int          REG_W               = 8;
    localparam logic [13:0] IDX_LINK_ENABLE     = 14'h0200;
    localparam logic [13:0] IDX_OUTPUT_MODE     = 14'h0201;
    localparam logic [13:0] IDX_FRAMES_M1       = 14'h0202;
    localparam logic [13:0] IDX_SW_SYNC         = 14'h0203;
    localparam logic [13:0] IDX_LINK_CONTROL    = 14'h0204;
    localparam logic [15:0] ADDR_LINK_ENABLE    = {IDX_LINK_ENABLE, 2'h0};
    localparam logic [15:0] ADDR_OUTPUT_MODE    = {IDX_OUTPUT_MODE, 2'h0};
    localparam logic [15:0] ADDR_FRAMES_M1      = {IDX_FRAMES_M1, 2'h0};
    localparam logic [15:0] ADDR_SW_SYNC        = {IDX_SW_SYNC, 2'h0};
    localparam logic [15:0] ADDR_LINK_CONTROL   = {IDX_LINK_CONTROL, 2'h0};

    // ****************************************************************
    // Reset values and field positions
    // ****************************************************************
    localparam logic [7:0]  RST_LINK_ENABLE     = 8'h01;
    localparam logic [7:0]  RST_OUTPUT_MODE     = 8'h00;
    localparam logic [7:0]  RST_FRAMES_M1       = 8'h1f;
    localparam logic [7:0]  RST_SW_SYNC         = 8'h01;
    localparam logic [7:0]  RST_LINK_CONTROL    = 8'h03;
    localparam int          ENABLE_BIT          = 0;
    localparam int          SW_SYNC_BIT         = 0;
    localparam int          MODE_MSB            = 5;
    localparam int          SYNC_SEL_LSB        = 2;
    localparam int          SYNC_SEL_MSB        = 3;
    localparam int          K64_NUMERATOR       = 256;
    localparam int          K_MIN_WIDTH         = 11;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        SLCR_SYNC_SE    = 2'b00,
        SLCR_SYNC_TMSTP = 2'b01,
        SLCR_SYNC_SW    = 2'b10,
        SLCR_SYNC_RSVD  = 2'b11
    } slcr_sync_src_t;

    typedef struct packed {
        logic holdReset;
        logic powerDown;
        logic clockEnable;
    } slcr_link_ctl_t;

endpackage

// ---- logic/slcr_serial_link_regs.sv ----
// Purpose: APB register bank controlling the serial link output subsystem.
// Assumes: All inputs are synchronous to clk; mode E and F come from the mode table.
// Notes:   Zero-wait APB slave; unmapped addresses answer with pslverr.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module slcr_serial_link_regs #(
    parameter int KW = 11
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [15:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   sysrefPulse,
    input  wire logic                   frameTick,
    input  wire logic                   syncSeN,
    input  wire logic                   tmstpSyncN,
    input  wire logic                   mode64b66b,
    input  wire logic [2:0]             modeE,
    input  wire logic [4:0]             modeF,
    output slcr_pkg::slcr_link_ctl_t    linkCtl,
    output logic      [5:0]             outputModeSelector,
    output logic      [KW-1:0]          effectiveK,
    output logic                        syncRequest,
    output logic      [KW-1:0]          multiframeCount,
    output logic                        multiframeBoundary
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    generate
        if (KW < slcr_pkg::K_MIN_WIDTH) begin : g_bad_kw
            $error("KW too narrow for the largest effective K");
        end
    endgenerate

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0]                 linkEnable_q;
    logic [7:0]                 linkOutputMode_q;
    logic [7:0]                 framesM1_q;
    logic [7:0]                 swSync_q;
    logic [7:0]                 linkControl_q;
    logic [31:0]                prdata_q;
    slcr_pkg::slcr_link_ctl_t   linkCtl_q;
    slcr_pkg::slcr_link_ctl_t   linkCtl_d;
    logic                       syncRequest_q;
    logic                       syncRequest_d;
    logic [KW-1:0]              effectiveK_q;
    logic [KW-1:0]              effectiveK_d;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire setupPhase  = psel && !penable;
    wire accessPhase = psel && penable;
    wire hitEnable   = (paddr == slcr_pkg::ADDR_LINK_ENABLE);
    wire hitMode     = (paddr == slcr_pkg::ADDR_OUTPUT_MODE);
    wire hitFramesM1 = (paddr == slcr_pkg::ADDR_FRAMES_M1);
    wire hitSwSync   = (paddr == slcr_pkg::ADDR_SW_SYNC);
    wire hitControl  = (paddr == slcr_pkg::ADDR_LINK_CONTROL);
    wire hitAny      = hitEnable || hitMode || hitFramesM1 || hitSwSync || hitControl;
    wire writeLane0  = accessPhase && pwrite && pstrb[0] && hitAny;
    wire [7:0] wrByte = pwdata[7:0];

    // ****************************************************************
    // Read data selection
    // ****************************************************************
    // full readback
    wire [7:0] readByte = hitEnable   ? linkEnable_q     :
                          hitMode     ? linkOutputMode_q :
                          hitFramesM1 ? framesM1_q       :
                          hitSwSync   ? swSync_q         :
                          hitControl  ? linkControl_q    : 8'h00;

    // ****************************************************************
    // APB answer
    // ****************************************************************
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !hitAny;
    assign prdata  = prdata_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata_q <= {24'h00_0000, readByte};
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // enable reset value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linkEnable_q     <= slcr_pkg::RST_LINK_ENABLE;
            linkOutputMode_q <= slcr_pkg::RST_OUTPUT_MODE;
            framesM1_q       <= slcr_pkg::RST_FRAMES_M1;
            swSync_q         <= slcr_pkg::RST_SW_SYNC;
            linkControl_q    <= slcr_pkg::RST_LINK_CONTROL;
        end else if (writeLane0) begin
            if (hitEnable) begin
                linkEnable_q <= wrByte;
            end
            if (hitMode) begin
                linkOutputMode_q <= wrByte;
            end
            if (hitFramesM1) begin
                framesM1_q <= wrByte;
            end
            if (hitSwSync) begin
                swSync_q <= wrByte;
            end
            if (hitControl) begin
                linkControl_q <= wrByte;
            end
        end
    end

    // ****************************************************************
    // Link enable effects and output mode selector
    // ****************************************************************
    wire linkOn = linkEnable_q[slcr_pkg::ENABLE_BIT];

    assign linkCtl_d.holdReset   = !linkOn;
    assign linkCtl_d.powerDown   = !linkOn;
    assign linkCtl_d.clockEnable = linkOn;

    assign outputModeSelector = linkOutputMode_q[slcr_pkg::MODE_MSB:0];

    // ****************************************************************
    // Effective frames per multiframe
    // ****************************************************************
    wire [KW-1:0] kFromReg = KW'(framesM1_q) + KW'(1);
    wire [KW-1:0] kNumer   = KW'(slcr_pkg::K64_NUMERATOR) * KW'(modeE);
    wire [KW-1:0] kFrom64  = kNumer / KW'(modeF);
    wire          use64    = mode64b66b && (modeF != 5'h00);

    assign effectiveK_d = use64 ? kFrom64 : kFromReg;

    // ****************************************************************
    // Synchronization request
    // ****************************************************************
    slcr_pkg::slcr_sync_src_t syncSel;
    assign syncSel = slcr_pkg::slcr_sync_src_t'(
        linkControl_q[slcr_pkg::SYNC_SEL_MSB:slcr_pkg::SYNC_SEL_LSB]);

    wire swSyncReq = !swSync_q[slcr_pkg::SW_SYNC_BIT];

    wire pinSyncReq = (syncSel == slcr_pkg::SLCR_SYNC_SE)    ? !syncSeN   :
                      (syncSel == slcr_pkg::SLCR_SYNC_TMSTP) ? !tmstpSyncN : 1'b0;

    assign syncRequest_d = swSyncReq || pinSyncReq;

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linkCtl_q     <= '{holdReset: 1'b0, powerDown: 1'b0, clockEnable: 1'b1};
            syncRequest_q <= 1'b0;
            effectiveK_q  <= KW'(slcr_pkg::RST_FRAMES_M1) + KW'(1);
        end else begin
            linkCtl_q     <= linkCtl_d;
            syncRequest_q <= syncRequest_d;
            effectiveK_q  <= effectiveK_d;
        end
    end

    assign linkCtl     = linkCtl_q;
    assign syncRequest = syncRequest_q;
    assign effectiveK  = effectiveK_q;

    // ****************************************************************
    // Multiframe counter
    // ****************************************************************
    // counter follows enable
    slcr_mf_counter #(
        .KW (KW)
    ) u_mf_counter (
        .clk         (clk),
        .resetn      (resetn),
        .enable      (linkOn),
        .sysrefPulse (sysrefPulse),
        .frameTick   (frameTick),
        .kValue      (effectiveK_q),
        .count       (multiframeCount),
        .boundary    (multiframeBoundary)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_disable_holds_link: assert property (
        @(posedge clk) disable iff (!resetn)
        !linkOn |=> (linkCtl.holdReset && linkCtl.powerDown && !linkCtl.clockEnable))
        else $error("link not held while disabled");

    a_enable_runs_link: assert property (
        @(posedge clk) disable iff (!resetn)
        linkOn |=> (!linkCtl.holdReset && linkCtl.clockEnable))
        else $error("link not running while enabled");

    a_counter_held_off: assert property (
        @(posedge clk) disable iff (!resetn)
        (!linkOn && sysrefPulse) |=> (multiframeCount == '0) && !multiframeBoundary)
        else $error("multiframe counter moved while disabled");

    a_mode_field_only: assert property (
        @(posedge clk) disable iff (!resetn)
        (writeLane0 && hitMode)
            |=> (outputModeSelector == $past(wrByte[slcr_pkg::MODE_MSB:0]))
                && (linkOutputMode_q == $past(wrByte)))
        else $error("mode selector does not follow register");

    a_k_plus_one: assert property (
        @(posedge clk) disable iff (!resetn)
        (!mode64b66b && $stable(framesM1_q))
            |=> effectiveK == KW'($past(framesM1_q)) + KW'(1))
        else $error("effective K is not length plus one");

    a_k_derived_64b: assert property (
        @(posedge clk) disable iff (!resetn)
        (use64 && $stable(modeE) && $stable(modeF))
            |=> (effectiveK == $past(kFrom64)))
        else $error("64B/66B K not derived from E and F");

    a_sw_sync_requests: assert property (
        @(posedge clk) disable iff (!resetn)
        swSyncReq |=> syncRequest)
        else $error("software sync did not raise a request");

    a_stuck_pin_holds: assert property (
        @(posedge clk) disable iff (!resetn)
        (syncSel == slcr_pkg::SLCR_SYNC_SE && !syncSeN)[*2] |-> syncRequest)
        else $error("stuck sync pin request released");

    a_sel_two_pins_off: assert property (
        @(posedge clk) disable iff (!resetn)
        (syncSel == slcr_pkg::SLCR_SYNC_SW && !swSyncReq) |=> !syncRequest)
        else $error("sync pins not ignored with selector two");

    a_readback_word: assert property (
        @(posedge clk) disable iff (!resetn)
        (setupPhase && !pwrite && hitFramesM1)
            |=> (prdata == {24'h00_0000, framesM1_q}))
        else $error("read data does not match stored length");

    a_write_takes_effect: assert property (
        @(posedge clk) disable iff (!resetn)
        (writeLane0 && hitSwSync && !pwdata[slcr_pkg::SW_SYNC_BIT])
            |=> ##1 syncRequest)
        else $error("software sync write did not request resync");

    a_reset_length: assert property (
        @(posedge clk)
        $rose(resetn) |-> (framesM1_q == slcr_pkg::RST_FRAMES_M1)
            && (effectiveK == KW'(32)))
        else $error("length register reset value wrong");

endmodule
